// ==== rtl/gpc_pkg.sv ====
// constants for the eight-pin general purpose I/O block
package gpc_pkg;
  localparam int          PIN_COUNT      = 8;
  localparam int          FUNC_LSB       = 0;
  localparam int          DIR_LSB        = 8;
  localparam int          VALUE_LSB      = 16;
  localparam int          RSVD_LSB       = 24;
  localparam logic [7:0]  FUNC_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  VALUE_RESET    = 8'h00;
  localparam logic [7:0]  RSVD_VALUE     = 8'h00;
  localparam int          CLOCK_PERIOD_NS = 20;
  localparam int          SAMPLE_TIME_NS = 128;
  // least spacing rounds up to whole cycles
  localparam int          SAMPLE_CYCLES  =
    (SAMPLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0]  SAMPLE_LAST    = 4'(SAMPLE_CYCLES - 1);
  localparam int          PIN_PORT_B_RST = 0;
  localparam int          PIN_PORT_C_RST = 1;
  localparam int          PIN_PORT_A_UP  = 2;
  localparam int          PIN_PORT_B_UP  = 3;
  localparam int          PIN_PORT_C_UP  = 4;
  localparam int          PIN_FAILOVER   = 5;
endpackage

// ==== rtl/gpc_pin_control.sv ====
// eight-pin general purpose I/O block with its control and status register
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_control #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // configuration access from port A space
  input  wire logic              CFG_WR,
  input  wire logic [3:0]        CFG_BE,
  input  wire logic [31:0]       CFG_WDATA,
  output logic      [31:0]       CFG_RDATA,
  // alternate function sources, active low
  input  wire logic              PORT_B_RESET_N,
  input  wire logic              PORT_C_RESET_N,
  input  wire logic              PORT_A_LINK_UP_N,
  input  wire logic              PORT_B_LINK_UP_N,
  input  wire logic              PORT_C_LINK_UP_N,
  // failover request to failover logic
  output logic                   UPSTREAM_FAILOVER_REQUEST,
  // pins
  input  wire logic [WIDTH-1:0]  PIN_IN,
  output logic      [WIDTH-1:0]  PIN_OUT,
  output logic      [WIDTH-1:0]  PIN_OE
);

  logic [WIDTH-1:0] pin_function_select;
  logic [WIDTH-1:0] pin_direction;
  logic [WIDTH-1:0] pin_value;
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] sampled;
  logic [3:0]       sample_cnt;
  logic [WIDTH-1:0] next_function_select;
  logic [WIDTH-1:0] next_direction;
  logic [WIDTH-1:0] next_value;
  logic [WIDTH-1:0] next_sampled;
  logic [3:0]       next_sample_cnt;
  logic [WIDTH-1:0] next_pin_out;
  logic [WIDTH-1:0] next_pin_oe;
  logic [WIDTH-1:0] alt_level;
  logic [WIDTH-1:0] alt_drives;
  logic [WIDTH-1:0] gp_out;
  logic [WIDTH-1:0] present_level;

  // alternate output levels; pins without a function never drive
  always_comb begin
    alt_level  = '1;
    alt_drives = '0;
    alt_level[gpc_pkg::PIN_PORT_B_RST]  = PORT_B_RESET_N;
    alt_level[gpc_pkg::PIN_PORT_C_RST]  = PORT_C_RESET_N;
    alt_level[gpc_pkg::PIN_PORT_A_UP]   = PORT_A_LINK_UP_N;
    alt_level[gpc_pkg::PIN_PORT_B_UP]   = PORT_B_LINK_UP_N;
    alt_level[gpc_pkg::PIN_PORT_C_UP]   = PORT_C_LINK_UP_N;
    alt_drives[gpc_pkg::PIN_PORT_B_RST] = 1'b1;
    alt_drives[gpc_pkg::PIN_PORT_C_RST] = 1'b1;
    alt_drives[gpc_pkg::PIN_PORT_A_UP]  = 1'b1;
    alt_drives[gpc_pkg::PIN_PORT_B_UP]  = 1'b1;
    alt_drives[gpc_pkg::PIN_PORT_C_UP]  = 1'b1;
    alt_drives[gpc_pkg::PIN_FAILOVER]   = 1'b0;
  end

  // per-pin mode decode, bit n only touches pin n
  assign gp_out = ~pin_function_select & pin_direction;

  // driven pins read back what is driven, others the sampled input
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_function_select[i] && alt_drives[i]) begin
        present_level[i] = alt_level[i];
      end else if (gp_out[i]) begin
        present_level[i] = pin_value[i];
      end else begin
        present_level[i] = sampled[i];
      end
    end
  end

  // input sampling paced to the fastest allowed rate
  always_comb begin
    next_sampled    = sampled;
    next_sample_cnt = sample_cnt - 4'h1;
    if (sample_cnt == 4'h0) begin
      next_sampled    = sync_b;
      next_sample_cnt = gpc_pkg::SAMPLE_LAST;
    end
  end

  // register next values
  always_comb begin
    next_function_select = pin_function_select;
    next_direction       = pin_direction;
    next_value           = pin_value;
    // general inputs track the pin, outputs hold what was written
    for (int i = 0; i < WIDTH; i++) begin
      if (!gp_out[i]) begin
        next_value[i] = present_level[i];
      end
    end
    if (CFG_WR) begin
      if (CFG_BE[0]) begin
        next_function_select = CFG_WDATA[gpc_pkg::FUNC_LSB +: 8];
      end
      if (CFG_BE[1]) begin
        next_direction = CFG_WDATA[gpc_pkg::DIR_LSB +: 8];
      end
      if (CFG_BE[2]) begin
        for (int i = 0; i < WIDTH; i++) begin
          if (gp_out[i]) begin
            next_value[i] = CFG_WDATA[gpc_pkg::VALUE_LSB + i];
          end
        end
      end
      // byte 3 is reserved and dropped
    end
  end

  // pin drivers; a general pin ignores its alternate source
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_function_select[i]) begin
        next_pin_oe[i]  = alt_drives[i];
        next_pin_out[i] = alt_drives[i] & alt_level[i];
      end else begin
        next_pin_oe[i]  = gp_out[i];
        next_pin_out[i] = gp_out[i] & pin_value[i];
      end
    end
  end

  // pin levels cross into the clock domain first
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pin_function_select       <= gpc_pkg::FUNC_RESET;
      pin_direction             <= gpc_pkg::DIR_RESET;
      pin_value                 <= gpc_pkg::VALUE_RESET;
      sampled                   <= gpc_pkg::VALUE_RESET;
      sample_cnt                <= gpc_pkg::SAMPLE_LAST;
      PIN_OUT                   <= '0;
      PIN_OE                    <= '0;
      CFG_RDATA                 <= '0;
      UPSTREAM_FAILOVER_REQUEST <= 1'b0;
    end else begin
      pin_function_select <= next_function_select;
      pin_direction       <= next_direction;
      pin_value           <= next_value;
      sampled             <= next_sampled;
      sample_cnt          <= next_sample_cnt;
      PIN_OUT             <= next_pin_out;
      PIN_OE              <= next_pin_oe;
      // read data loads the same next values as the register, so it matches the register
      CFG_RDATA <= {gpc_pkg::RSVD_VALUE, next_value,
                    next_direction, next_function_select};
      // pin 5 level goes to failover logic whatever its mode
      UPSTREAM_FAILOVER_REQUEST <= sync_b[gpc_pkg::PIN_FAILOVER];
    end
  end

endmodule // gpc_pin_control
`default_nettype wire

// ==== test/gpc_pin_control_assertions.sv ====
// port checks for the pin control block
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_control_assertions #(parameter int WIDTH = 8) (
  input wire logic             MCLK, RST_N, CFG_WR, UPSTREAM_FAILOVER_REQUEST,
  input wire logic [3:0]       CFG_BE,
  input wire logic [31:0]      CFG_WDATA, CFG_RDATA,
  input wire logic             PORT_B_RESET_N, PORT_C_RESET_N,
  input wire logic             PORT_A_LINK_UP_N, PORT_B_LINK_UP_N, PORT_C_LINK_UP_N,
  input wire logic [WIDTH-1:0] PIN_IN, PIN_OUT, PIN_OE
);
  logic [3:0]       quiet, next_quiet;
  logic [WIDTH-1:0] last_in;
  logic [4:0]       alt_src;
  logic [7:0]       func, gp_out;
  assign func = CFG_RDATA[7:0];
  assign gp_out = ~func & CFG_RDATA[15:8];
  assign alt_src = {PORT_C_LINK_UP_N, PORT_B_LINK_UP_N, PORT_A_LINK_UP_N,
                    PORT_C_RESET_N, PORT_B_RESET_N};
  // any pin or config change restarts the settle count
  always_comb next_quiet = (CFG_WR || PIN_IN != last_in) ? 4'h0 : quiet + 4'(quiet != 4'hf);
  always_ff @(posedge MCLK) begin
    quiet   <= RST_N ? next_quiet : 4'h0;
    last_in <= PIN_IN;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_rsvd_zero: assert property (CFG_RDATA[31:24] == 8'h00)
    else $error("reserved byte not zero");
  a_cfg_write: assert property (CFG_WR && CFG_BE[1:0] == 2'h3 |=>
    CFG_RDATA[15:0] == $past(CFG_WDATA[15:0])) else $error("config write lost");
  a_value_write: assert property (CFG_WR && CFG_BE[2] |=>
    ((CFG_RDATA[23:16] ^ $past(CFG_WDATA[23:16])) & $past(gp_out)) == 8'h00)
    else $error("output value write lost");
  a_oe_config: assert property (PIN_OE == $past(gp_out | (func & 8'h1f)))
    else $error("pin enable wrong");
  a_gp_drive: assert property (((PIN_OUT ^ $past(CFG_RDATA[23:16])) & $past(gp_out)) == 8'h00)
    else $error("output level wrong");
  a_alt_drive: assert property (((PIN_OUT[4:0] ^ $past(alt_src)) & $past(func[4:0])) == 5'h00)
    else $error("alternate output wrong");
  a_fail_follow: assert property ($past(RST_N, 3) && $past(RST_N, 2) && $past(RST_N) |->
    UPSTREAM_FAILOVER_REQUEST == $past(PIN_IN[5], 3)) else $error("failover request wrong");
  a_read_level: assert property (quiet > 4'ha |-> CFG_RDATA[23:16] == PIN_IN)
    else $error("pin readback wrong");
endmodule // gpc_pin_control_assertions
`default_nettype wire

// ==== test/gpc_board_model.sv ====
// board logic on the far side of the pins, pulled up where nobody drives
`timescale 1ns/100ps
`default_nettype none
module gpc_board_model (
  input  wire logic [7:0] pin_out, pin_oe, board_val, board_en,
  output logic      [7:0] pin_level
);
  // device outputs taken as plain levels, no clock relation assumed
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~board_en) | (~pin_oe & board_en & board_val);
endmodule // gpc_board_model
`default_nettype wire

// ==== test/gpc_pin_control_test.sv ====
// self-checking bench for the pin control block
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_control_test;
  logic        mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, fail;
  logic [3:0]  be = 4'h0;
  logic [4:0]  src = 5'h1f;
  logic [31:0] wdata = 32'h0, rdata;
  logic [7:0]  lvl, pout, poe, bval = 8'h00, ben = 8'h00;
  int          errors = 0, n_checks = 0, cycles = 0;
  gpc_pin_control #(.WIDTH(8)) uut (.MCLK(mclk), .RST_N(rst_n), .CFG_WR(wr), .CFG_BE(be),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .PORT_B_RESET_N(src[0]), .PORT_C_RESET_N(src[1]),
    .PORT_A_LINK_UP_N(src[2]), .PORT_B_LINK_UP_N(src[3]), .PORT_C_LINK_UP_N(src[4]),
    .UPSTREAM_FAILOVER_REQUEST(fail), .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE(poe));
  gpc_board_model board (.pin_out(pout), .pin_oe(poe), .board_val(bval), .board_en(ben),
    .pin_level(lvl));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) if (++cycles == 3000) begin errors++; wrap_up(); end
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin errors++; $display("BAD %s exp %h got %h", what, exp, got); end
  endtask
  task automatic idle(input int n); repeat (n) @(posedge mclk); #2; endtask
  task automatic cfg(input logic [3:0] b, input logic [31:0] d);
    @(posedge mclk) #2 {wr, be, wdata} = {1'b1, b, d};
    @(posedge mclk) #2 wr = 1'b0;
  endtask
  // all outputs, reserved byte written with ones
  // value byte obeys the direction already in force, so direction goes first
  task automatic t_gp_out();
    cfg(4'h3, 32'hffa5ff00); cfg(4'hc, 32'hffa5ff00); idle(2);
    chk("out enable", 32'hff, 32'(poe));
    chk("out level", 32'ha5, 32'(pout));
    chk("register", 32'h00a5ff00, rdata);
  endtask
  // low nibble driven, high nibble read from the board
  task automatic t_gp_in();
    cfg(4'h2, 32'h00000f00);
    {bval, ben} = {8'h50, 8'hf0};
    cfg(4'h4, 32'h00ff0000); idle(12);
    chk("mixed pins", 32'h5f, 32'(rdata[23:16]));
  endtask
  // direction left at 0f must not matter once all pins go alternate
  task automatic t_alt();
    {bval, ben, src} = {8'h70, 8'he0, 5'h0a};
    cfg(4'h1, 32'h000000ff); idle(12);
    chk("alt enable", 32'h1f, 32'(poe));
    chk("alt level", 32'h0a, 32'(pout[4:0]));
    chk("alt read", 32'h6a, 32'(rdata[23:16]));
    chk("failover", 32'h1, 32'(fail));
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    idle(3); rst_n = 1'b1;
    chk("reset reg", 32'h0, rdata);
    chk("reset enable", 32'h0, 32'(poe));
    t_gp_out(); t_gp_in(); t_alt();
    wrap_up();
  end
endmodule // gpc_pin_control_test
bind gpc_pin_control gpc_pin_control_assertions #(.WIDTH(WIDTH)) chk_i (.MCLK(MCLK),
  .RST_N(RST_N), .CFG_WR(CFG_WR), .UPSTREAM_FAILOVER_REQUEST(UPSTREAM_FAILOVER_REQUEST),
  .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .PORT_B_RESET_N(PORT_B_RESET_N),
  .PORT_C_RESET_N(PORT_C_RESET_N), .PORT_A_LINK_UP_N(PORT_A_LINK_UP_N),
  .PORT_B_LINK_UP_N(PORT_B_LINK_UP_N), .PORT_C_LINK_UP_N(PORT_C_LINK_UP_N),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
`default_nettype wire
